// >>> psd_ctrl_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// controller model: one bus cycle per call, write data shown two
// qualified edges after its command, released lanes keep toggling
module psd_ctrl_model (
  // clock
  input wire logic i_clk,
  // controls, selects packed as {one_n, two, three_n}
  output logic o_clock_qualify_n,
  output logic [2:0] o_chip_selects,
  output logic o_write_select_n,
  output logic o_advance_or_load,
  output logic [psd_pkg::LANES-1:0] o_byte_write_select_n,
  output logic [psd_pkg::ADDR_W-1:0] o_addr,
  // write data and parity lanes
  output psd_pkg::psd_word_t o_word
);
  import psd_pkg::*;
  localparam logic [2:0] SEL = 3'h2;
  psd_word_t wd;
  logic wb;
  logic [36:0] s1;
  logic [36:0] s2;
  logic [1:0] k;

  // idle, deselected bus at time zero
  initial begin
    o_clock_qualify_n = 1'h0;
    o_chip_selects = 3'h6;
    o_write_select_n = 1'h1;
    o_advance_or_load = 1'h0;
    o_byte_write_select_n = 4'hf;
    o_addr = '0;
    o_word = '0;
    wd = '0;
    wb = 1'h0;
    s1 = '0;
    s2 = '0;
    k = 2'h0;
  end

  // one cycle after a falling edge; a deselect drops one enable in turn
  task automatic cyc(input logic q_n, input logic sel, input logic we_n,
                     input logic adv, input logic [3:0] bw_n,
                     input logic [17:0] a, input psd_word_t w);
    @(negedge i_clk);
    o_clock_qualify_n = q_n;
    o_chip_selects = sel ? SEL : SEL ^ (3'h4 >> k);
    k = (k == 2'h2) ? 2'h0 : k + 2'h1;
    o_write_select_n = we_n;
    o_advance_or_load = adv;
    o_byte_write_select_n = bw_n;
    o_addr = a;
    wd = w;
  endtask : cyc

  // write phase tracking; a burst keeps the type latched at its load
  always @(posedge i_clk) begin
    if (!o_clock_qualify_n) begin
      if (!o_advance_or_load) begin
        wb <= !o_write_select_n && o_chip_selects == SEL;
      end
      s1 <= {o_advance_or_load ? wb :
             !o_write_select_n && o_chip_selects == SEL, wd};
      s2 <= s1;
    end
  end

  // data in its phase, otherwise the inverse of the last value
  always @(negedge i_clk) begin
    o_word <= s2[36] ? psd_word_t'(s2[35:0]) : ~o_word;
  end
endmodule : psd_ctrl_model

// >>> psd_pkg.sv
package psd_pkg;
  // widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int LEVEL_W = 4;
  localparam int MEM_WORDS = 1 << ADDR_W;
  // sleep entry and exit each take this many clocks
  localparam logic [1:0] SLEEP_CYCLES = 2'h2;
  localparam logic [1:0] SLEEP_STEP = 2'h1;
  localparam logic [1:0] SLEEP_NONE = 2'h0;
  // burst counter
  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [LANES-1:0] PAR_RST = 4'h0;
  localparam logic [LANES-1:0] BW_NONE_N = 4'hf;
  localparam logic [LEVEL_W-1:0] LEVEL_ONE = 4'h1;
  // pipeline stage: one access in flight
  typedef struct packed {
    logic valid;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bw_n;
  } psd_op_t;
  // one stored word: data lanes plus parity lanes
  typedef struct packed {
    logic [LANES-1:0] par;
    logic [DATA_W-1:0] data;
  } psd_word_t;
  // queued write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bw_n;
    psd_word_t word;
  } psd_wentry_t;
  localparam psd_op_t OP_RST = '{valid: 1'b0, wr: 1'b0, addr: '0,
                                 bw_n: BW_NONE_N};
  localparam psd_word_t WORD_RST = '{par: PAR_RST, data: DATA_RST};
  // test access port states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } psd_tap_t;
endpackage : psd_pkg

// >>> psd_top.sv
// What this block does
// R1 - act on clock edges only when qualifier low
// R2 - qualifier high stretches cycle, keeps all state
// R3 - capture write data lanes on rising clock
// R4 - read drives data addressed one edge earlier
// R5 - output-drive enable high forces lanes tristate
// R6 - tristate during write data, deselect, emerging
// R7 - parity lanes follow data, gated by byte selects
// R8 - strap high interleaved order, low linear
// R9 - system keeps burst strap constant
// R10 - test output changes on falling test clock
// R11 - test input sampled on rising test clock
// R12 - mode select steers tap on rising edge
// R13 - sleep input enters data-preserving sleep
// R14 - system holds sleep low for normal operation
// R15 - write select low writes, high reads
// R16 - advance low loads address, high advances burst
// R17 - stalled output register keeps read data
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// write queue: W-bit words, DEPTH entries
module psd_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // honest flags from the occupancy count
  assign o_ready = (cnt_ff != DEPTH_CNT);
  assign o_valid = (cnt_ff != '0);
  assign o_data = mem_ff[rd_ff];
  assign o_level = cnt_ff;
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // pointer and count next values
  always_comb begin
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wr = (wr_ff == PTR_LAST) ? '0 : PW'(wr_ff + 1'b1);
    end
    if (pop) begin
      nxt_rd = (rd_ff == PTR_LAST) ? '0 : PW'(rd_ff + 1'b1);
    end
    if (push & ~pop) begin
      nxt_cnt = (PW+1)'(cnt_ff + 1'b1);
    end else if (pop & ~push) begin
      nxt_cnt = (PW+1)'(cnt_ff - 1'b1);
    end
  end

  // pointer registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage has no reset
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_data;
    end
  end
endmodule : psd_fifo

////////////////////////////////////////////////////////////////////////////
module psd_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // synchronous controls
  input wire logic i_clock_qualify_n,
  input wire logic i_chip_select_one_n,
  input wire logic i_chip_select_two,
  input wire logic i_chip_select_three_n,
  input wire logic i_write_select_n,
  input wire logic i_advance_or_load,
  input wire logic [psd_pkg::LANES-1:0] i_byte_write_select_n,
  input wire logic [psd_pkg::ADDR_W-1:0] i_addr,
  // asynchronous output-drive enable
  input wire logic i_output_drive_n,
  // data and parity lanes
  input wire logic [psd_pkg::DATA_W-1:0] i_dq,
  input wire logic [psd_pkg::LANES-1:0] i_parity_lanes,
  output logic [psd_pkg::DATA_W-1:0] o_dq,
  output logic [psd_pkg::LANES-1:0] o_parity_lanes,
  output logic o_lane_oe,
  // strap and sleep
  input wire logic i_burst_order,
  input wire logic i_sleep_request,
  output logic o_asleep,
  // test port
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo
);
  import psd_pkg::*;

  psd_word_t mem_ff [MEM_WORDS];
  psd_op_t op_ff, nxt_op, s2_ff, nxt_s2;
  psd_word_t out_ff, nxt_out, rd_word;
  psd_wentry_t push_entry, head;
  logic [BURST_W-1:0] base_ff, nxt_base, cnt_ff, nxt_cnt;
  logic oe_ff, nxt_oe, order_ff, nxt_order;
  logic [1:0] zz_cnt_ff, nxt_zz_cnt;
  logic asleep_ff, nxt_asleep;
  logic ce_on, qual, read_wait, push, in_ready, head_valid, drain;
  logic [LEVEL_W-1:0] level;
  psd_tap_t tap_ff, nxt_tap;
  logic tck_prev_ff, shift_ff, nxt_shift, tdo_ff, nxt_tdo;
  logic tck_rise, tck_fall, shifting;

  // next burst low address bits in the selected order
  function automatic logic [BURST_W-1:0] burst_lo(
    input logic [BURST_W-1:0] base,
    input logic [BURST_W-1:0] cnt,
    input logic interleave
  );
    burst_lo = interleave ? (base ^ cnt) : BURST_W'(base + cnt); // R8
  endfunction : burst_lo

  // overlay the enabled lanes of a queued word onto a stored one
  function automatic psd_word_t merge(
    input psd_word_t old,
    input psd_word_t upd,
    input logic [LANES-1:0] bw_n
  );
    merge = old;
    for (int i = 0; i < LANES; i++) begin
      if (!bw_n[i]) begin
        merge.data[i*LANE_W +: LANE_W] = upd.data[i*LANE_W +: LANE_W];
        merge.par[i] = upd.par[i]; // R7
      end
    end
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // qualification and stall
  assign ce_on = ~i_chip_select_one_n & i_chip_select_two &
                 ~i_chip_select_three_n;
  // a read waits while older queued writes are still behind the head
  assign read_wait = op_ff.valid & ~op_ff.wr & (level > LEVEL_ONE);
  // full queue or sleep stall the pipeline like a raised qualifier
  assign qual = ~i_clock_qualify_n & in_ready & ~asleep_ff & ~read_wait; // R1
  assign push = qual & s2_ff.valid & s2_ff.wr; // R3
  assign push_entry = '{addr: s2_ff.addr, bw_n: s2_ff.bw_n,
                        word: '{par: i_parity_lanes, data: i_dq}}; // R3
  assign drain = head_valid & ~asleep_ff;

  // write queue between data capture and the array
  psd_fifo #(
    .W($bits(psd_wentry_t)),
    .DEPTH(FIFO_DEPTH)
  ) psd_fifo_inst (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_valid(push),
    .o_ready(in_ready),
    .i_data(push_entry),
    .o_valid(head_valid),
    .i_ready(~asleep_ff),
    .o_data(head),
    .o_level(level)
  );

  // array write port, lanes gated by the byte selects
  always_ff @(posedge i_clk) begin
    if (drain) begin
      mem_ff[head.addr] <=
        merge(mem_ff[head.addr], head.word, head.bw_n); // R7
    end
  end

  // read word with forwarding from the queue head and incoming data
  always_comb begin
    rd_word = mem_ff[op_ff.addr];
    if (head_valid && head.addr == op_ff.addr) begin
      rd_word = merge(rd_word, head.word, head.bw_n);
    end
    if (push && s2_ff.addr == op_ff.addr) begin
      rd_word = merge(rd_word, push_entry.word, push_entry.bw_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command and data pipeline next values
  always_comb begin
    nxt_op = op_ff;
    nxt_s2 = s2_ff;
    nxt_base = base_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    nxt_oe = oe_ff;
    if (qual) begin // R2
      nxt_s2 = op_ff;
      if (i_advance_or_load) begin
        // burst continues regardless of chip selects and write select
        if (op_ff.valid) begin // R16
          nxt_cnt = BURST_W'(cnt_ff + BURST_STEP);
          nxt_op.addr = {op_ff.addr[ADDR_W-1:BURST_W],
                         burst_lo(base_ff, nxt_cnt, order_ff)};
          nxt_op.bw_n = i_byte_write_select_n;
        end
      end else begin
        nxt_op.valid = ce_on; // R16
        nxt_op.wr = ~i_write_select_n; // R15
        nxt_op.addr = i_addr;
        nxt_op.bw_n = i_byte_write_select_n;
        nxt_base = i_addr[BURST_W-1:0];
        nxt_cnt = BURST_START;
      end
      // read data leaves one edge after its address was taken
      if (op_ff.valid && !op_ff.wr) begin
        nxt_out = rd_word; // R4
      end
      // write data phase, deselect and emerging all drive nothing
      nxt_oe = op_ff.valid & ~op_ff.wr; // R6
    end
    if (asleep_ff) begin
      nxt_oe = 1'b0; // R13
    end
  end

  // pipeline registers; stalled edges keep every value except oe_ff, which sleep clears
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      op_ff <= OP_RST;
      s2_ff <= OP_RST;
      base_ff <= BURST_START;
      cnt_ff <= BURST_START;
      out_ff <= WORD_RST;
      oe_ff <= 1'b0;
    end else begin
      op_ff <= nxt_op;
      s2_ff <= nxt_s2;
      base_ff <= nxt_base;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out; // R17
      oe_ff <= nxt_oe;
    end
  end

  // lanes: registered data, enable masked by the drive pin
  assign o_dq = out_ff.data;
  assign o_parity_lanes = out_ff.par;
  assign o_lane_oe = oe_ff & ~i_output_drive_n; // R5

  ////////////////////////////////////////////////////////////////////////
  // burst-order strap caught while reset is held
  always_comb begin
    nxt_order = i_reset_n ? order_ff : i_burst_order; // R8
  end

  always_ff @(posedge i_clk) begin
    order_ff <= nxt_order;
  end

  ////////////////////////////////////////////////////////////////////////
  // sleep: two clocks to enter, two to leave
  always_comb begin
    nxt_zz_cnt = zz_cnt_ff;
    nxt_asleep = asleep_ff;
    if (i_sleep_request && zz_cnt_ff != SLEEP_CYCLES) begin
      nxt_zz_cnt = 2'(zz_cnt_ff + SLEEP_STEP);
    end else if (!i_sleep_request && zz_cnt_ff != SLEEP_NONE) begin
      nxt_zz_cnt = 2'(zz_cnt_ff - SLEEP_STEP);
    end
    if (nxt_zz_cnt == SLEEP_CYCLES) begin
      nxt_asleep = 1'b1; // R13
    end else if (nxt_zz_cnt == SLEEP_NONE) begin
      nxt_asleep = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      zz_cnt_ff <= SLEEP_NONE;
      asleep_ff <= 1'b0;
    end else begin
      zz_cnt_ff <= nxt_zz_cnt;
      asleep_ff <= nxt_asleep;
    end
  end

  assign o_asleep = asleep_ff;

  ////////////////////////////////////////////////////////////////////////
  // test port: test clock sampled as an ordinary input
  assign tck_rise = i_tck & ~tck_prev_ff;
  assign tck_fall = ~i_tck & tck_prev_ff;
  assign shifting = (tap_ff == TAP_SHIFT_DR) | (tap_ff == TAP_SHIFT_IR);

  // tap state, one-bit bypass path and output latch
  always_comb begin
    nxt_tap = tap_ff;
    nxt_shift = shift_ff;
    nxt_tdo = tdo_ff;
    if (tck_rise) begin // R12
      case (tap_ff)
        TAP_RESET: nxt_tap = i_tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: nxt_tap = i_tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: nxt_tap = i_tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: nxt_tap = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: nxt_tap = i_tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: nxt_tap = i_tms ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: nxt_tap = i_tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: nxt_tap = i_tms ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR: nxt_tap = i_tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: nxt_tap = i_tms ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: nxt_tap = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: nxt_tap = i_tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: nxt_tap = i_tms ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: nxt_tap = i_tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: nxt_tap = i_tms ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR: nxt_tap = i_tms ? TAP_SEL_DR : TAP_IDLE;
        default: nxt_tap = TAP_RESET;
      endcase
      if (shifting) begin
        nxt_shift = i_tdi; // R11
      end
    end
    if (tck_fall) begin
      nxt_tdo = shifting & shift_ff; // R10
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tap_ff <= TAP_RESET;
      tck_prev_ff <= 1'b0;
      shift_ff <= 1'b0;
      tdo_ff <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
      tck_prev_ff <= i_tck;
      shift_ff <= nxt_shift;
      tdo_ff <= nxt_tdo;
    end
  end

  assign o_tdo = tdo_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_read_taken;
    qual && op_ff.valid && !op_ff.wr;
  endsequence

  sequence s_read_driven;
    oe_ff && (out_ff == $past(rd_word));
  endsequence

  property p_stall_hold;
    !qual |=> $stable(op_ff) && $stable(s2_ff) && $stable(cnt_ff);
  endproperty
  a_stall_hold: assert property (p_stall_hold) // R2
    else $error("pipeline moved on a stalled edge");

  property p_out_keep;
    !qual && !asleep_ff |=> $stable(out_ff) && $stable(oe_ff);
  endproperty
  a_out_keep: assert property (p_out_keep) // R17
    else $error("output register changed while stalled");

  property p_read_latency;
    s_read_taken |=> s_read_driven;
  endproperty
  a_read_latency: assert property (p_read_latency) // R4
    else $error("read data not driven one edge after address");

  property p_drive_mask;
    i_output_drive_n |-> !o_lane_oe;
  endproperty
  a_drive_mask: assert property (p_drive_mask) // R5
    else $error("lanes driven while drive enable high");

  property p_write_tristate;
    qual && op_ff.valid && op_ff.wr |=> !oe_ff && s2_ff.valid && s2_ff.wr;
  endproperty
  a_write_tristate: assert property (p_write_tristate) // R6
    else $error("lanes driven in write data phase");

  property p_desel_tristate;
    qual && !op_ff.valid |=> !oe_ff;
  endproperty
  a_desel_tristate: assert property (p_desel_tristate) // R6
    else $error("lanes driven while deselected");

  property p_capture;
    push |=> head_valid && head.addr == $past(s2_ff.addr) &&
      head.word == $past({i_parity_lanes, i_dq});
  endproperty
  a_capture: assert property (p_capture) // R3
    else $error("write data not taken from the lanes");

  property p_strap_const;
    ##1 $stable(order_ff);
  endproperty
  a_strap_const: assert property (p_strap_const) // R8
    else $error("burst order changed after reset");

  property p_tdo_fall;
    !tck_fall |=> $stable(o_tdo);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) // R10
    else $error("test output moved off the falling edge");

  property p_tap_idle;
    tap_ff == TAP_RESET && tck_rise && !i_tms |=> tap_ff == TAP_IDLE;
  endproperty
  a_tap_idle: assert property (p_tap_idle) // R12
    else $error("tap did not leave reset on mode select low");

  property p_sleep_quiet;
    asleep_ff |-> !qual ##1 !oe_ff;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) // R13
    else $error("activity during sleep");

  property p_load;
    qual && !i_advance_or_load |=> op_ff.addr == $past(i_addr) &&
      op_ff.valid == $past(ce_on);
  endproperty
  a_load: assert property (p_load) // R16
    else $error("address not loaded");
endmodule : psd_top

// >>> psd_top_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////
module psd_top_bench;
  import psd_pkg::*;
  logic clk, rst_n, drive_n, strap, sleep, tck, tms, tdi;
  logic cq_n, we_n, adv, oe, asleep, tdo;
  logic [2:0] cs;
  logic [LANES-1:0] bw_n;
  logic [LANES-1:0] par;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq;
  psd_word_t wd;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  psd_top psd_top_inst (
    .i_clk(clk),
    .i_reset_n(rst_n),
    .i_clock_qualify_n(cq_n),
    .i_chip_select_one_n(cs[2]),
    .i_chip_select_two(cs[1]),
    .i_chip_select_three_n(cs[0]),
    .i_write_select_n(we_n),
    .i_advance_or_load(adv),
    .i_byte_write_select_n(bw_n),
    .i_addr(addr),
    .i_output_drive_n(drive_n),
    .i_dq(wd.data),
    .i_parity_lanes(wd.par),
    .o_dq(dq),
    .o_parity_lanes(par),
    .o_lane_oe(oe),
    .i_burst_order(strap),
    .i_sleep_request(sleep),
    .o_asleep(asleep),
    .i_tck(tck),
    .i_tms(tms),
    .i_tdi(tdi),
    .o_tdo(tdo)
  );

  psd_ctrl_model psd_ctrl_model_inst (
    .i_clk(clk),
    .o_clock_qualify_n(cq_n),
    .o_chip_selects(cs),
    .o_write_select_n(we_n),
    .o_advance_or_load(adv),
    .o_byte_write_select_n(bw_n),
    .o_addr(addr),
    .o_word(wd)
  );

  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic summarize;
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [35:0] seen,
                     input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // bus cycle shorthands
  task automatic rd(input logic [17:0] a);
    psd_ctrl_model_inst.cyc(1'h0, 1'h1, 1'h1, 1'h0, 4'hf, a, '0);
  endtask : rd

  task automatic wr(input logic [17:0] a, input logic [3:0] b,
                    input psd_word_t w);
    psd_ctrl_model_inst.cyc(1'h0, 1'h1, 1'h0, 1'h0, b, a, w);
  endtask : wr

  task automatic nop;
    psd_ctrl_model_inst.cyc(1'h0, 1'h0, 1'h1, 1'h0, 4'hf, '0, '0);
  endtask : nop

  task automatic do_reset(input logic s);
    @(negedge clk);
    rst_n = 1'h0;
    strap = s;
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    chk("reset lanes", {par, dq}, '0);
    chk("reset flags", {oe, asleep, tdo}, '0);
  endtask : do_reset

  // byte-gated writes merged, read back, output enable phases
  task automatic t_write_read;
    wr(18'h5, 4'h0, {4'hf, 32'h1111_2222});
    wr(18'h5, 4'h5, {4'h0, 32'haaaa_bbbb});
    rd(18'h5);
    chk("oe write phase", oe, 1'h0);
    nop;
    nop;
    chk("merged word", {par, dq}, {4'h5, 32'haa11_bb22});
    chk("oe read", oe, 1'h1);
    drive_n = 1'h1;
    #1 chk("oe drive off", oe, 1'h0);
    drive_n = 1'h0;
    #1 chk("oe drive on", oe, 1'h1);
    nop;
    chk("oe deselected", oe, 1'h0);
    rd(18'h5);
    nop;
    chk("oe emerging", oe, 1'h0);
  endtask : t_write_read

  // qualifier high with deselect and write shown: all ignored
  task automatic t_stall;
    wr(18'h9, 4'h0, {4'h3, 32'h1234_5678});
    nop;
    nop;
    nop;
    rd(18'h9);
    repeat (3) begin
      psd_ctrl_model_inst.cyc(1'h1, 1'h0, 1'h0, 1'h0, 4'h0, '0, '0);
    end
    chk("stalled data", {par, dq}, {4'h5, 32'haa11_bb22});
    nop;
    chk("stall end data", {par, dq}, {4'h5, 32'haa11_bb22});
    nop;
    chk("stretched read", {par, dq}, {4'h3, 32'h1234_5678});
    chk("stretched oe", oe, 1'h1);
  endtask : t_stall

  // burst from base 1 in the order set by the strap
  task automatic t_burst(input logic s);
    int lo;
    do_reset(s);
    for (int i = 0; i < 4; i++) begin
      wr(18'h8 + 18'(i), 4'h0, {4'(i), 32'h0000_0c00 + 32'(i)});
    end
    nop;
    nop;
    for (int b = 0; b < 6; b++) begin
      if (b == 0) begin
        rd(18'h9);
      end else if (b < 4) begin
        psd_ctrl_model_inst.cyc(1'h0, 1'h0, 1'h0, 1'h1, 4'hf, '0, '0);
      end else begin
        nop;
      end
      if (b >= 2) begin
        lo = s ? (1 ^ (b - 2)) : ((b - 1) & 3);
        chk("beat", {par, dq}, {4'(lo), 32'(lo) + 32'h0000_0c00});
      end
    end
  endtask : t_burst

  // two clocks in, two out, contents kept
  task automatic t_sleep;
    nop;
    sleep = 1'h1;
    nop;
    chk("asleep early", asleep, 1'h0);
    nop;
    chk("asleep", asleep, 1'h1);
    sleep = 1'h0;
    nop;
    nop;
    chk("awake", asleep, 1'h0);
    repeat (4) nop;
    rd(18'h9);
    nop;
    nop;
    chk("kept word", {par, dq}, {4'h1, 32'h0000_0c01});
  endtask : t_sleep

  // one slow test clock period with output checked around the fall
  task automatic tap(input logic ms, input logic di, input logic hi,
                     input logic lo);
    @(negedge clk);
    tms = ms;
    tdi = di;
    @(negedge clk);
    tck = 1'h1;
    repeat (3) @(negedge clk);
    chk("tdo before fall", tdo, hi);
    tck = 1'h0;
    repeat (3) @(negedge clk);
    chk("tdo after fall", tdo, lo);
  endtask : tap

  task automatic t_tap;
    tap(1'h0, 1'h0, 1'h0, 1'h0);
    tap(1'h1, 1'h0, 1'h0, 1'h0);
    tap(1'h0, 1'h1, 1'h0, 1'h0);
    tap(1'h0, 1'h1, 1'h0, 1'h0);
    tap(1'h0, 1'h1, 1'h0, 1'h1);
    tap(1'h0, 1'h0, 1'h1, 1'h0);
    tap(1'h1, 1'h1, 1'h0, 1'h0);
    tap(1'h1, 1'h0, 1'h0, 1'h0);
  endtask : t_tap

  // main sequence
  initial begin
    rst_n = 1'h0;
    drive_n = 1'h0;
    strap = 1'h1;
    sleep = 1'h0;
    tck = 1'h0;
    tms = 1'h0;
    tdi = 1'h0;
    do_reset(1'h1);
    t_write_read();
    t_stall();
    t_burst(1'h1);
    t_burst(1'h0);
    t_sleep();
    t_tap();
    summarize();
  end
endmodule : psd_top_bench
